/* File: bench/pccsig_card.sv */
// pccsig_card.sv: behavioural 16-bit card on the socket pins
// assumes active-low strobes from the controller and knobs from the bench
`timescale 1ns/10ps
module pccsig_card (
  input wire clk,
  input wire output_enable_n,
  input wire write_enable_n,
  input wire io_read_strobe_n,
  input wire io_write_strobe_n,
  input wire memory_only_mode,
  input wire card_busy,
  input wire irq_pend,
  input wire wp_sw,
  input wire wide,
  input wire [3:0] wait_len,
  input wire [15:0] rd_word,
  output reg [15:0] data_in,
  output wire ready_irq_n,
  output wire wait_n,
  output wire wp_wide_n
);
  reg [3:0] drv = 4'h0;
  reg [3:0] wcnt = 4'h0;
  reg strobe_d = 1'b0;
  wire rd_on = !output_enable_n || !io_read_strobe_n;
  wire strobe = rd_on || !write_enable_n || !io_write_strobe_n;
  initial data_in = 16'h0;
  assign ready_irq_n = memory_only_mode ? !card_busy : !irq_pend;
  assign wp_wide_n = memory_only_mode ? wp_sw : !wide;
  assign wait_n = (wcnt == 4'h0);
  always @(posedge clk) begin
    strobe_d <= strobe;
    drv <= rd_on ? 4'h4 : (drv != 4'h0 ? drv - 4'h1 : 4'h0);
    // a released bus toggles so a stale value cannot pass for read data
    data_in <= (rd_on || drv != 4'h0) ? rd_word : ~data_in;
    wcnt <= (strobe && !strobe_d) ? wait_len : (wcnt != 4'h0 ? wcnt - 4'h1 : 4'h0);
  end
endmodule

/* File: bench/pccsig_ctrl_chk.sv */
// pccsig_ctrl_chk.sv: timing checks on the socket strobes
// assumes a bind into pccsig_ctrl, one clk domain
`timescale 1ns/10ps
module pccsig_ctrl_chk (
  input wire clk,
  input wire rst_n,
  input wire req,
  input wire busy,
  input wire done,
  input wire card_reset,
  input wire card_reset_req,
  input wire output_enable_n,
  input wire write_enable_n,
  input wire io_read_strobe_n,
  input wire io_write_strobe_n,
  input wire attribute_select_n,
  input wire data_oe_n,
  input wire wait_n,
  input wire memory_only_mode,
  input wire card_ready,
  input wire card_interrupt_request
);
  // ****
  // checks
  // ****
  wire quiet = &{output_enable_n, write_enable_n, io_read_strobe_n, io_write_strobe_n};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_idle; (!busy && !done) |-> quiet && attribute_select_n; endproperty
  a_idle: assert property (p_idle) else $error("strobe low while idle");
  property p_rst; $past(rst_n) |-> card_reset == $past(card_reset_req); endproperty
  a_rst: assert property (p_rst) else $error("card reset not following request");
  property p_take; (req && !busy && !card_reset) |=> busy ##0 !done[*7]; endproperty
  a_take: assert property (p_take) else $error("access taken wrongly");
  property p_wait; (!wait_n[*6] ##0 !quiet) |=> !quiet; endproperty
  a_wait: assert property (p_wait) else $error("strobe ended during wait");
  property p_wr; !io_write_strobe_n |-> !data_oe_n; endproperty
  a_wr: assert property (p_wr) else $error("write strobe without data");
  property p_rd; !io_read_strobe_n |-> data_oe_n && io_write_strobe_n; endproperty
  a_rd: assert property (p_rd) else $error("read strobe with data driven");
  property p_mode; memory_only_mode[*3] |-> !card_interrupt_request; endproperty
  a_mode: assert property (p_mode) else $error("interrupt in memory mode");
  property p_oewe; !(!output_enable_n && !write_enable_n); endproperty
  a_oewe: assert property (p_oewe) else $error("read and write strobes together");
endmodule

bind pccsig_ctrl pccsig_ctrl_chk u_chk (.clk, .rst_n, .req, .busy, .done, .card_reset,
  .card_reset_req, .output_enable_n, .write_enable_n, .io_read_strobe_n, .io_write_strobe_n,
  .attribute_select_n, .data_oe_n, .wait_n, .memory_only_mode, .card_ready,
  .card_interrupt_request);

/* File: bench/test_pccsig_ctrl.sv */
// test_pccsig_ctrl.sv: self-checking bench for the socket control block
// assumes pccsig_card on the pins and the checker bound in
`timescale 1ns/10ps
module test_pccsig_ctrl;
  logic clk = 0;
  logic rst_n = 0;
  logic req = 0;
  logic [2:0] req_kind = 0;
  logic req_attr = 0;
  logic req_tc = 0;
  logic [1:0] req_bytes = 0;
  logic [15:0] req_wdata = 0;
  logic memory_only_mode = 1;
  logic card_reset_req = 0;
  logic voltage_sense_a_in = 1;
  logic voltage_sense_b_in = 1;
  logic card_busy = 0, irq_pend = 0, wp_sw = 0, wide = 0;
  logic [3:0] wait_len = 0;
  logic [15:0] rd_word = 16'h5aa5;
  logic [15:0] seen, wseen;
  int cyc, ticks, err_total, compares;
  wire busy, done, rdata_wide, card_reset, even_byte_enable_n, odd_byte_enable_n;
  wire output_enable_n, write_enable_n, io_read_strobe_n, io_write_strobe_n;
  wire attribute_select_n, data_oe_n, ready_irq_n, wait_n, wp_wide_n, card_ready;
  wire card_interrupt_request, write_protected, dma_request, wide_port_indication;
  wire [15:0] rdata, data_out, data_in;
  wire [1:0] card_voltage;
  pccsig_ctrl dut (.clk, .rst_n, .req, .req_kind, .req_attr, .req_tc, .req_bytes, .req_wdata,
    .busy, .done, .rdata, .rdata_wide, .memory_only_mode, .card_reset_req, .card_reset,
    .even_byte_enable_n, .odd_byte_enable_n, .output_enable_n, .write_enable_n,
    .io_read_strobe_n, .io_write_strobe_n, .attribute_select_n, .data_out, .data_oe_n,
    .data_in, .ready_irq_n, .wait_n, .wp_wide_n, .voltage_sense_a_in, .voltage_sense_b_in,
    .card_ready, .card_interrupt_request, .write_protected, .dma_request,
    .wide_port_indication, .card_voltage);
  pccsig_card card (.clk, .output_enable_n, .write_enable_n, .io_read_strobe_n,
    .io_write_strobe_n, .memory_only_mode, .card_busy, .irq_pend, .wp_sw, .wide, .wait_len,
    .rd_word, .data_in, .ready_irq_n, .wait_n, .wp_wide_n);
  always #10 clk = ~clk;
  // ****
  // helpers
  // ****
  task close_out;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    ticks++;
    if (ticks == 5000) begin
      err_total++;
      close_out;
    end
  end
  task chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task settle;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask
  task run(input [2:0] k, input a, input t, input [1:0] b, input [15:0] w);
    @(posedge clk);
    req <= 1'b1;
    req_kind <= k;
    req_attr <= a;
    req_tc <= t;
    req_bytes <= b;
    req_wdata <= w;
    @(posedge clk);
    req <= 1'b0;
    seen = 16'h0;
    cyc = 0;
    while (done !== 1'b1 && cyc < 200) begin
      @(negedge clk);
      cyc++;
      seen[6:0] = seen[6:0] | ~{output_enable_n, write_enable_n, io_read_strobe_n,
        io_write_strobe_n, attribute_select_n, even_byte_enable_n, odd_byte_enable_n};
      if (data_oe_n === 1'b0) wseen = data_out;
    end
    chk("done seen", cyc < 200, 1);
  endtask
  // ****
  // scenarios
  // ****
  task t_mem;
    run(3'h0, 1'b0, 1'b0, 2'h1, 16'h0);
    chk("mem rd lines", seen, 16'h42);
    chk("mem rd data", rdata, 16'h5aa5);
    chk("plain length", cyc < 14, 1);
    run(3'h1, 1'b1, 1'b0, 2'h2, 16'hc33c);
    chk("mem wr lines", seen, 16'h25);
    chk("mem wr data", wseen, 16'hc33c);
  endtask
  task t_wait;
    wait_len = 4'hc;
    run(3'h0, 1'b0, 1'b0, 2'h3, 16'h0);
    chk("wait length", cyc > 16, 1);
    wait_len = 4'h0;
  endtask
  task t_io;
    @(posedge clk);
    memory_only_mode <= 1'b0;
    wide <= 1'b1;
    rd_word <= 16'h1e87;
    settle;
    run(3'h2, 1'b0, 1'b0, 2'h3, 16'h0);
    chk("io rd lines", seen, 16'h17);
    chk("io rd data", rdata, 16'h1e87);
    chk("io rd wide", rdata_wide, 1);
    run(3'h3, 1'b0, 1'b0, 2'h3, 16'h6d29);
    chk("io wr lines", seen, 16'h0f);
    chk("io wr data", wseen, 16'h6d29);
  endtask
  task t_dma;
    run(3'h4, 1'b0, 1'b1, 2'h3, 16'h0f0f);
    chk("dma rd tc lines", seen, 16'h2f);
    run(3'h5, 1'b0, 1'b1, 2'h3, 16'h0);
    chk("dma wr tc lines", seen, 16'h57);
    run(3'h4, 1'b0, 1'b0, 2'h3, 16'h0f0f);
    chk("dma rd lines", seen, 16'h0f);
  endtask
  task t_stat;
    irq_pend = 1'b1;
    settle;
    chk("irq", card_interrupt_request, 1);
    chk("ready in io mode", card_ready, 0);
    chk("wide port", wide_port_indication, 1);
    chk("dma request", dma_request, 1);
    @(posedge clk);
    memory_only_mode <= 1'b1;
    card_busy <= 1'b1;
    wp_sw <= 1'b1;
    settle;
    chk("busy card", card_ready, 0);
    chk("protect", write_protected, 1);
    chk("irq in mem mode", card_interrupt_request, 0);
    card_busy = 1'b0;
    settle;
    chk("ready card", card_ready, 1);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {voltage_sense_a_in, voltage_sense_b_in} <= i[1:0];
      settle;
      chk("voltage", card_voltage, {14'h0000, ~i[1:0]});
    end
  endtask
  task t_reset;
    @(posedge clk);
    card_reset_req <= 1'b1;
    settle;
    chk("card reset on", card_reset, 1);
    @(posedge clk);
    req <= 1'b1;
    settle;
    chk("refused in reset", busy, 0);
    @(posedge clk);
    req <= 1'b0;
    card_reset_req <= 1'b0;
    settle;
    chk("card reset off", card_reset, 0);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    settle;
    t_mem;
    t_wait;
    t_io;
    t_dma;
    t_stat;
    t_reset;
    close_out;
  end
endmodule

/* File: rtl/pccsig_ctrl.v */
// pccsig_ctrl.v: control-strobe sequencer for a 16-bit card socket
// assumes a host request port on clk; card pins are asynchronous
//
// How it works
// RQ1: memory read drives output enable low
// RQ2: output enable marks DMA write terminal count
// RQ3: card holds ready low while busy
// RQ4: card raises ready when free
// RQ5: ready line is interrupt unless memory-only
// RQ6: card pulls interrupt low to request service
// RQ7: attribute select high for common memory
// RQ8: attribute select steers to attribute or I/O
// RQ9: attribute select is DMA acknowledge with I/O strobe
// RQ10: card reset output forces hard reset
// RQ11: two sense lines give card voltage
// RQ12: wait stretches the active strobe phase
// RQ13: write enable clocks memory write data
// RQ14: write enable marks DMA read terminal count
// RQ15: card shows write-protect switch state
// RQ16: card flags sixteen-bit I/O port
// RQ17: write protect serves as DMA request
// RQ18: I/O read strobe, also card-to-host DMA
// RQ19: I/O write strobe, also host-to-card DMA
// RQ20: even and odd byte enables
// RQ21: active-low lines, idle outputs deasserted
`timescale 1ns/10ps
`include "pccsig_defs.vh"
module pccsig_ctrl #(
  parameter CW = `PCCSIG_CNT_W
) (
  input wire clk,
  input wire rst_n,
  input wire req,
  input wire [2:0] req_kind,
  input wire req_attr,
  input wire req_tc,
  input wire [1:0] req_bytes,
  input wire [15:0] req_wdata,
  output reg busy,
  output reg done,
  output reg [15:0] rdata,
  output reg rdata_wide,
  input wire memory_only_mode,
  input wire card_reset_req,
  output reg card_reset,
  output reg even_byte_enable_n,
  output reg odd_byte_enable_n,
  output reg output_enable_n,
  output reg write_enable_n,
  output reg io_read_strobe_n,
  output reg io_write_strobe_n,
  output reg attribute_select_n,
  output reg [15:0] data_out,
  output reg data_oe_n,
  input wire [15:0] data_in,
  input wire ready_irq_n,
  input wire wait_n,
  input wire wp_wide_n,
  input wire voltage_sense_a_in,
  input wire voltage_sense_b_in,
  output reg card_ready,
  output reg card_interrupt_request,
  output reg write_protected,
  output reg dma_request,
  output reg wide_port_indication,
  output reg [1:0] card_voltage
);
  // ************
  // sequencer states
  // ************
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_SETUP = 2'h1;
  localparam [1:0] ST_STROBE = 2'h2;
  localparam [1:0] ST_HOLD = 2'h3;

  // ************
  // pin synchronisers
  // ************
  wire [4:0] pins_sync;
  wire rdy_s;
  wire wait_s;
  wire wp_s;
  wire vsa_s;
  wire vsb_s;
  pccsig_sync #(.W(5), .INIT(5'h1f)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({ready_irq_n, wait_n, wp_wide_n, voltage_sense_a_in, voltage_sense_b_in}),
    .q(pins_sync)
  );
  assign rdy_s = pins_sync[4];
  assign wait_s = pins_sync[3];
  assign wp_s = pins_sync[2];
  assign vsa_s = pins_sync[1];
  assign vsb_s = pins_sync[0];

  // sense pins grounded by the card read low; open reads high
  function [1:0] volt_decode;
    input a;
    input b;
    begin
      case ({a, b})
        2'b10: volt_decode = `PCCSIG_VOLT_3V;
        2'b01: volt_decode = `PCCSIG_VOLT_XV;
        2'b00: volt_decode = `PCCSIG_VOLT_LOW;
        default: volt_decode = `PCCSIG_VOLT_5V;
      endcase
    end
  endfunction

  // ************
  // status outputs
  // ************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      card_ready <= 1'b0;
      card_interrupt_request <= 1'b0;
      write_protected <= 1'b0;
      dma_request <= 1'b0;
      wide_port_indication <= 1'b0;
      card_voltage <= `PCCSIG_VOLT_5V;
      card_reset <= 1'b1;
    end else begin
      card_ready <= memory_only_mode & rdy_s; // RQ5
      card_interrupt_request <= ~memory_only_mode & ~rdy_s; // RQ5
      write_protected <= memory_only_mode & wp_s;
      // dma request is asserted when the pin is driven low
      dma_request <= ~wp_s;
      wide_port_indication <= ~memory_only_mode & ~wp_s;
      card_voltage <= volt_decode(vsa_s, vsb_s); // RQ11
      card_reset <= card_reset_req; // RQ10
    end
  end

  // ************
  // access sequencer
  // ************
  reg [1:0] state;
  reg [CW-1:0] cnt;
  reg [2:0] kind;
  reg attr;
  reg tc;
  reg [1:0] bytes;
  reg [1:0] next_state;
  reg [CW-1:0] next_cnt;
  wire is_dma;
  wire is_rd;
  wire strobe_on;
  assign is_dma = (kind == `PCCSIG_KIND_DMA_RD) || (kind == `PCCSIG_KIND_DMA_WR);
  assign is_rd = (kind == `PCCSIG_KIND_MEM_RD) || (kind == `PCCSIG_KIND_IO_RD) ||
                 (kind == `PCCSIG_KIND_DMA_WR);
  assign strobe_on = (next_state == ST_STROBE);

  always @* begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      ST_IDLE: begin
        if (req && !card_reset) begin
          next_state = ST_SETUP;
          next_cnt = `PCCSIG_SETUP_CYC;
        end
      end
      ST_SETUP: begin
        if (cnt == {CW{1'b0}} + 1'b1) begin
          next_state = ST_STROBE;
          next_cnt = `PCCSIG_STROBE_CYC;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_STROBE: begin
        // the strobe phase cannot end while the synchronised wait_s is low
        if (cnt > {{(CW-1){1'b0}}, 1'b1}) begin
          next_cnt = cnt - 1'b1;
        end else if (wait_s) begin // RQ12
          next_state = ST_HOLD;
          next_cnt = `PCCSIG_HOLD_CYC;
        end
      end
      ST_HOLD: begin
        if (cnt == {{(CW-1){1'b0}}, 1'b1}) begin
          next_state = ST_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt <= {CW{1'b0}};
      kind <= `PCCSIG_KIND_MEM_RD;
      attr <= 1'b0;
      tc <= 1'b0;
      bytes <= 2'h0;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
      rdata_wide <= 1'b0;
      data_out <= 16'h0000;
      data_oe_n <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      done <= (state == ST_HOLD) && (next_state == ST_IDLE);
      busy <= (next_state != ST_IDLE);
      if (state == ST_IDLE && req && !card_reset) begin
        kind <= req_kind;
        attr <= req_attr;
        tc <= req_tc;
        bytes <= req_bytes;
        data_out <= req_wdata;
        data_oe_n <= (req_kind == `PCCSIG_KIND_MEM_RD) ||
                     (req_kind == `PCCSIG_KIND_IO_RD) ||
                     (req_kind == `PCCSIG_KIND_DMA_WR);
      end else if (next_state == ST_IDLE) begin
        data_oe_n <= 1'b1;
      end
      if (state == ST_STROBE && next_state == ST_HOLD && is_rd) begin
        rdata <= data_in;
        rdata_wide <= ~wp_s;
      end
    end
  end

  // ************
  // card strobes, all active low and idle high
  // ************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      output_enable_n <= 1'b1; // RQ21
      write_enable_n <= 1'b1;
      io_read_strobe_n <= 1'b1;
      io_write_strobe_n <= 1'b1;
      attribute_select_n <= 1'b1;
      even_byte_enable_n <= 1'b1;
      odd_byte_enable_n <= 1'b1;
    end else if (state == ST_IDLE || next_state == ST_IDLE) begin
      // on the take edge kind, bytes and tc still hold the last access
      output_enable_n <= 1'b1; // RQ21
      write_enable_n <= 1'b1;
      io_read_strobe_n <= 1'b1;
      io_write_strobe_n <= 1'b1;
      attribute_select_n <= 1'b1;
      even_byte_enable_n <= 1'b1;
      odd_byte_enable_n <= 1'b1;
    end else begin
      even_byte_enable_n <= ~bytes[0]; // RQ20
      odd_byte_enable_n <= ~bytes[1]; // RQ20
      // io and dma cycles assert select; common memory keeps it high
      attribute_select_n <= ~(attr | is_dma | (kind == `PCCSIG_KIND_IO_RD) |
                              (kind == `PCCSIG_KIND_IO_WR)); // RQ7 RQ8 RQ9
      // terminal count rides the memory strobes over the whole dma cycle
      output_enable_n <= ~((strobe_on && kind == `PCCSIG_KIND_MEM_RD) ||
                           (tc && kind == `PCCSIG_KIND_DMA_WR)); // RQ1 RQ2
      write_enable_n <= ~((strobe_on && kind == `PCCSIG_KIND_MEM_WR) ||
                          (tc && kind == `PCCSIG_KIND_DMA_RD)); // RQ13 RQ14
      io_read_strobe_n <= ~(strobe_on && (kind == `PCCSIG_KIND_IO_RD ||
                                          kind == `PCCSIG_KIND_DMA_WR)); // RQ18 RQ9
      io_write_strobe_n <= ~(strobe_on && (kind == `PCCSIG_KIND_IO_WR ||
                                           kind == `PCCSIG_KIND_DMA_RD)); // RQ19 RQ9
    end
  end
endmodule

/* File: rtl/pccsig_defs.vh */
// pccsig_defs.vh: constants for the 16-bit card socket control block
// assumes inclusion by bare name from rtl files
`ifndef PCCSIG_DEFS_VH
`define PCCSIG_DEFS_VH
// ************
// access kinds
// ************
`define PCCSIG_KIND_MEM_RD 3'h0
`define PCCSIG_KIND_MEM_WR 3'h1
`define PCCSIG_KIND_IO_RD 3'h2
`define PCCSIG_KIND_IO_WR 3'h3
`define PCCSIG_KIND_DMA_RD 3'h4
`define PCCSIG_KIND_DMA_WR 3'h5
// ************
// timing, in clk cycles at 50 MHz
// ************
`define PCCSIG_SETUP_CYC 4'h2
// strobe must outlast the wait pin's synchroniser delay, or a late wait is missed
`define PCCSIG_STROBE_CYC 4'h7
`define PCCSIG_HOLD_CYC 4'h2
`define PCCSIG_CNT_W 4
// ************
// voltage sense decode
// ************
`define PCCSIG_VOLT_5V 2'h0
`define PCCSIG_VOLT_3V 2'h1
`define PCCSIG_VOLT_XV 2'h2
`define PCCSIG_VOLT_LOW 2'h3
`endif

/* File: rtl/pccsig_sync.v */
// pccsig_sync.v: three-stage input synchroniser with agreement filter
// assumes asynchronous card pins; output changes once stages two and three agree
`timescale 1ns/10ps
module pccsig_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  genvar i;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          q[i] <= INIT[i];
        end else if (s2[i] == s3[i]) begin
          q[i] <= s3[i];
        end
      end
    end
  endgenerate
endmodule
